// ===== core/pint_regs.svh
`ifndef PINT_REGS_SVH
`define PINT_REGS_SVH
`define CHAN_NUM        8
`define PIN_SEL_W       6
`define PIN_NUM         64
`define SLICE_CFG_W     3
`define CFG_CONST_HIGH  3'h0
`define CFG_STICKY_RISE 3'h1
`define CFG_STICKY_FALL 3'h2
`define CFG_STICKY_BOTH 3'h3
`define CFG_HIGH_LEVEL  3'h4
`define CFG_LOW_LEVEL   3'h5
`define CFG_CONST_LOW   3'h6
`define CFG_EVENT_EDGE  3'h7
`define SEL_RESET       6'h00
`endif

// ===== core/pint_pkg.sv
package pint_pkg;
    typedef enum logic [1:0] {
        sense_rise,
        sense_fall,
        sense_both
    } edge_sense_t;
    typedef enum logic {
        op_pin_irq,
        op_pattern
    } op_mode_t;
endpackage

// ===== core/pin_sync.sv
`timescale 1ns/1ps
`include "pint_regs.svh"
// two-stage synchroniser for one selected pin plus previous level
module pin_sync (
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      prev_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;
    logic prev_reg;
    logic prev_next;

    // first stage is read only by the second stage
    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    assign level_out = sync_reg;
    assign prev_out  = prev_reg;
endmodule

// ===== core/pin_irq_pattern.sv
`timescale 1ns/1ps
`include "pint_regs.svh"
// Summary of operation
// RULE1: up to eight port 0/1 pins selected
// RULE2: one request line per channel
// RULE3: edge channels fire rising, falling or both
// RULE4: level channels follow high or low polarity
// RULE5: pin requests usable as sleep/deep-sleep wake
// RULE6: pattern mode takes eight pins as inputs
// RULE7: terms test levels, transitions or both
// RULE8: each product term raises its own request
// RULE9: pattern match pulses core event when enabled
// RULE10: core event pulse also drives a pin
// RULE11: pattern wake only from active and sleep
// RULE12: pin routing independent of pin function
// RULE13: all control is single-cycle, no wait
// RULE14: pins pass two flip-flops before use
module pin_irq_pattern
    import pint_pkg::*;
(
    input  wire logic                 mclk_in,
    input  wire logic                 rstn_in,
    input  wire logic [63:0]          port_pins_in,
    input  wire logic [47:0]          pin_sel_in,
    input  wire pint_pkg::op_mode_t   mode_in,
    input  wire logic [7:0]           level_mode_in,
    input  wire logic [7:0]           level_high_in,
    input  wire logic [15:0]          edge_sense_in,
    input  wire logic [7:0]           rise_clr_in,
    input  wire logic [7:0]           fall_clr_in,
    input  wire logic [23:0]          slice_src_in,
    input  wire logic [23:0]          slice_cfg_in,
    input  wire logic [7:0]           slice_end_in,
    input  wire logic                 event_en_in,
    input  wire logic                 deep_sleep_in,
    output logic [7:0]                irq_out,
    output logic [7:0]                rise_seen_out,
    output logic [7:0]                fall_seen_out,
    output logic [7:0]                pmatch_out,
    output logic                      core_event_pulse_out,
    output logic                      core_event_pin_out,
    output logic                      pin_wake_out,
    output logic                      pattern_wake_out
);
    import pint_pkg::*;

    logic [7:0] raw_pin;
    logic [7:0] lvl;
    logic [7:0] prv;
    logic [7:0] rise_ev;
    logic [7:0] fall_ev;

    // pin selection by index works whatever function owns the pin
    generate
        for (genvar c = 0; c < `CHAN_NUM; c++) begin : g_chan
            logic [5:0] sel;
            assign sel = pin_sel_in[c*6 +: 6];
            assign raw_pin[c] = port_pins_in[sel]; // RULE1 RULE6 RULE12
            pin_sync u_sync (
                .mclk_in   (mclk_in),
                .rstn_in   (rstn_in),
                .pin_in    (raw_pin[c]),
                .level_out (lvl[c]),
                .prev_out  (prv[c])
            ); // RULE14
            assign rise_ev[c] = lvl[c] & ~prv[c];
            assign fall_ev[c] = ~lvl[c] & prv[c];
        end
    endgenerate

    // sticky edge flags; a new edge wins over a clear in the same cycle
    logic [7:0] rise_reg;
    logic [7:0] rise_next;
    logic [7:0] fall_reg;
    logic [7:0] fall_next;
    logic [7:0] irq_reg;
    logic [7:0] irq_next;

    always_comb begin
        rise_next = (rise_reg & ~rise_clr_in) | rise_ev;
        fall_next = (fall_reg & ~fall_clr_in) | fall_ev;
        irq_next  = 8'h00;
        for (int c = 0; c < 8; c++) begin
            if (mode_in == op_pin_irq) begin
                if (level_mode_in[c]) begin
                    irq_next[c] = ~(lvl[c] ^ level_high_in[c]); // RULE4
                end else begin
                    unique case (edge_sense_in[c*2 +: 2])
                        2'h0:    irq_next[c] = rise_ev[c]; // RULE3
                        2'h1:    irq_next[c] = fall_ev[c]; // RULE3
                        default: irq_next[c] = rise_ev[c] | fall_ev[c];
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rise_reg <= 8'h00;
            fall_reg <= 8'h00;
            irq_reg  <= 8'h00;
        end else begin
            rise_reg <= rise_next;
            fall_reg <= fall_next;
            irq_reg  <= irq_next;
        end
    end

    // pattern slices: each slice tests one input, chained into products
    logic [7:0] slice_hit;
    logic [7:0] prod;
    logic [7:0] pm_reg;
    logic [7:0] pm_next;
    logic       ev_reg;
    logic       ev_next;

    always_comb begin
        for (int s = 0; s < 8; s++) begin
            logic [2:0] src;
            src = slice_src_in[s*3 +: 3];
            unique case (slice_cfg_in[s*3 +: 3]) // RULE7
                `CFG_CONST_HIGH:  slice_hit[s] = 1'b1;
                `CFG_STICKY_RISE: slice_hit[s] = rise_reg[src];
                `CFG_STICKY_FALL: slice_hit[s] = fall_reg[src];
                `CFG_STICKY_BOTH: slice_hit[s] = rise_reg[src] |
                                                 fall_reg[src];
                `CFG_HIGH_LEVEL:  slice_hit[s] = lvl[src];
                `CFG_LOW_LEVEL:   slice_hit[s] = ~lvl[src];
                `CFG_CONST_LOW:   slice_hit[s] = 1'b0;
                default:          slice_hit[s] = rise_ev[src] |
                                                 fall_ev[src];
            endcase
        end
        // product runs from the last endpoint to this slice
        for (int s = 0; s < 8; s++) begin
            if (s == 0 || slice_end_in[(s == 0) ? 0 : s-1]) begin
                prod[s] = slice_hit[s];
            end else begin
                prod[s] = prod[s-1] & slice_hit[s];
            end
        end
        pm_next = 8'h00;
        if (mode_in == op_pattern) begin
            pm_next = prod & slice_end_in; // RULE8
        end
        ev_next = event_en_in & (|pm_next) & ~(|pm_reg); // RULE9
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pm_reg <= 8'h00;
            ev_reg <= 1'b0;
        end else begin
            pm_reg <= pm_next;
            ev_reg <= ev_next;
        end
    end

    // outputs; control ports are plain wires so no access waits
    assign irq_out              = (mode_in == op_pattern) ? pm_reg
                                                          : irq_reg; // RULE2
    assign rise_seen_out        = rise_reg; // RULE13
    assign fall_seen_out        = fall_reg;
    assign pmatch_out           = pm_reg;
    assign core_event_pulse_out = ev_reg;
    assign core_event_pin_out   = ev_reg; // RULE10
    assign pin_wake_out         = |irq_reg; // RULE5
    // pattern wake is gated off by deep_sleep_in, so no pattern wake in deep sleep
    assign pattern_wake_out     = (|pm_reg) & ~deep_sleep_in; // RULE11

    edge_irq_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pin_irq && !level_mode_in[0]
         && edge_sense_in[1:0] == 2'h0 && rise_ev[0]) |=> irq_out[0])
        else $error("rising edge gave no request"); // RULE3
    level_irq_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pin_irq && level_mode_in[1] && level_high_in[1]
         && $stable(mode_in)) |=> (irq_reg[1] == $past(lvl[1])))
        else $error("level request wrong"); // RULE4
    sync_delay_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        rise_ev[0] |-> $past(lvl[0]) == 1'b0)
        else $error("edge without prior low"); // RULE14
    event_pulse_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        core_event_pulse_out |=> !core_event_pulse_out)
        else $error("event longer than a pulse"); // RULE9
    event_pin_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        core_event_pin_out == core_event_pulse_out)
        else $error("event pin mismatch"); // RULE10
    deep_wake_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        deep_sleep_in |-> !pattern_wake_out)
        else $error("pattern wake in deep sleep"); // RULE11
    slice_irq_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (pmatch_out != 8'h00) |-> $past(mode_in) == op_pattern)
        else $error("match outside pattern mode"); // RULE8
    sticky_set_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        rise_ev[2] |=> rise_seen_out[2])
        else $error("rise flag lost"); // RULE7
    pin_wake_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (irq_reg != 8'h00) |-> pin_wake_out)
        else $error("no pin wake"); // RULE5

    // edge channel checks look at irq_reg, not irq_out, so a mode
    // switch on the next edge cannot make them fire falsely
    fall_irq_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pin_irq && !level_mode_in[0]
         && edge_sense_in[1:0] == 2'h1 && fall_ev[0]) |=> irq_reg[0])
        else $error("falling edge gave no request"); // RULE3

    both_irq_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pin_irq && !level_mode_in[0] && edge_sense_in[1]
         && (rise_ev[0] || fall_ev[0])) |=> irq_reg[0])
        else $error("either edge gave no request"); // RULE3

    quiet_chan_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pin_irq && !level_mode_in[0]
         && !rise_ev[0] && !fall_ev[0]) |=> !irq_reg[0])
        else $error("edge request without edge"); // RULE3

    // level channels, both polarities
    level_low_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pin_irq && level_mode_in[2] && !level_high_in[2])
        |=> (irq_reg[2] == !$past(lvl[2])))
        else $error("low level request wrong"); // RULE4

    level_high_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pin_irq && level_mode_in[5] && level_high_in[5]
         && lvl[5]) |=> irq_reg[5])
        else $error("high level request missing"); // RULE4

    // request routing between the two modes
    chan_idle_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pattern) |=> (irq_reg == 8'h00))
        else $error("pin request in pattern mode"); // RULE2

    pattern_route_a: assert property (@(posedge mclk_in)
        disable iff (!rstn_in)
        (mode_in == op_pattern) |-> (irq_out == pmatch_out))
        else $error("pattern request not routed"); // RULE8

    pin_mode_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pin_irq) |=> (pmatch_out == 8'h00))
        else $error("match while in pin mode"); // RULE6

    // sticky flags: set wins, clear works, flag holds otherwise
    rise_clear_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (!rise_ev[3] && rise_clr_in[3]) |=> !rise_seen_out[3])
        else $error("rise flag not cleared"); // RULE7

    fall_set_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        fall_ev[3] |=> fall_seen_out[3])
        else $error("fall flag lost"); // RULE7

    rise_hold_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (rise_seen_out[4] && !rise_clr_in[4]) |=> rise_seen_out[4])
        else $error("rise flag dropped"); // RULE7

    // event pulse only when enabled, always on a new match
    event_gate_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !event_en_in |=> !core_event_pulse_out)
        else $error("event while disabled"); // RULE9

    event_start_a: assert property (@(posedge mclk_in)
        disable iff (!rstn_in)
        (event_en_in && pm_next != 8'h00 && pm_reg == 8'h00)
        |=> core_event_pulse_out)
        else $error("match start gave no event"); // RULE9

    // matches appear only on product endpoints
    slice_end_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (pmatch_out & ~$past(slice_end_in)) == 8'h00)
        else $error("match on a non-endpoint"); // RULE8

    const_low_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (mode_in == op_pattern && slice_cfg_in[2:0] == `CFG_CONST_LOW
         && slice_end_in[0]) |=> !pmatch_out[0])
        else $error("constant low slice matched"); // RULE8

    // wake outputs
    awake_wake_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (!deep_sleep_in && pmatch_out != 8'h00) |-> pattern_wake_out)
        else $error("pattern wake missing"); // RULE11

    idle_wake_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (irq_reg == 8'h00) |-> !pin_wake_out)
        else $error("pin wake without request"); // RULE5

    // synchroniser latency: a pin held two edges shows as level next
    sequence pin0_held_s;
        raw_pin[0] ##1 raw_pin[0];
    endsequence

    sequence pin0_rising_s;
        !lvl[0] ##1 lvl[0];
    endsequence

    sync_chain_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        pin0_held_s |=> lvl[0])
        else $error("pin level not synchronised"); // RULE14

    rise_detect_a: assert property (@(posedge mclk_in)
        disable iff (!rstn_in)
        pin0_rising_s |-> rise_ev[0])
        else $error("synced rise not detected"); // RULE14
endmodule

// ===== dv/pin_source.sv
`timescale 1ns/1ps
// stands in for the external pins; they are async to the block clock
module pin_source (
    input  wire logic        mclk_in,
    input  wire logic [63:0] want_in,
    input  wire logic        slow_in,
    output logic      [63:0] pins_out
);
    initial pins_out = 64'h0;
    // late landing checks that pin timing inside the cycle never matters
    always @(posedge mclk_in) begin
        pins_out <= #(slow_in ? 30 : 2) want_in;
    end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    import pint_pkg::*;
    logic mclk_in = 0, rstn_in = 0, ev_en = 0, deep = 0, slow = 0, ck = 0;
    logic [63:0] want = 64'h0, pins;
    logic [47:0] sel = 48'h0;
    op_mode_t    mode = op_pin_irq;
    logic [7:0]  lmode = 8'h0, lhigh = 8'h0, rclr = 8'h0, fclr = 8'h0;
    logic [7:0]  ends = 8'h0, irq, rs, fs, pm, s1, lv, pv;
    logic [7:0]  m_irq, m_rs, m_fs, m_pm, ir_n, pm_n;
    logic [15:0] sense = 16'h0;
    logic [23:0] src = 24'h0, cfg = 24'h0;
    logic        ev, evp, pwk, twk, m_ev, pr, t;
    int seed = 32'h3ff83855, err_count = 0, checks_done = 0, cyc = 0;
    always #25 mclk_in = ~mclk_in;

    pin_source u_pin_source (.mclk_in(mclk_in), .want_in(want),
        .slow_in(slow), .pins_out(pins));
    pin_irq_pattern u_pin_irq_pattern (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .port_pins_in(pins), .pin_sel_in(sel), .mode_in(mode),
        .level_mode_in(lmode), .level_high_in(lhigh), .edge_sense_in(sense),
        .rise_clr_in(rclr), .fall_clr_in(fclr), .slice_src_in(src),
        .slice_cfg_in(cfg), .slice_end_in(ends), .event_en_in(ev_en),
        .deep_sleep_in(deep), .irq_out(irq), .rise_seen_out(rs),
        .fall_seen_out(fs), .pmatch_out(pm), .core_event_pulse_out(ev),
        .core_event_pin_out(evp), .pin_wake_out(pwk),
        .pattern_wake_out(twk));

    // next requests and matches from the model's synced levels
    always_comb begin
        pr = 1'b1;
        for (int s = 0; s < 8; s++) begin
            case (cfg[3*s+:3])
                3'h0: t = 1'b1;
                3'h1: t = m_rs[src[3*s+:3]];
                3'h2: t = m_fs[src[3*s+:3]];
                3'h3: t = m_rs[src[3*s+:3]] | m_fs[src[3*s+:3]];
                3'h4: t = lv[src[3*s+:3]];
                3'h5: t = !lv[src[3*s+:3]];
                3'h7: t = lv[src[3*s+:3]] != pv[src[3*s+:3]];
                default: t = 1'b0;
            endcase
            pr = pr & t;
            pm_n[s] = ends[s] & pr & (mode == op_pattern);
            if (ends[s]) pr = 1'b1;
            ir_n[s] = lmode[s] ? lv[s] == lhigh[s] :
                (sense[2*s+:2] != 2'h1 && lv[s] && !pv[s]) ||
                (sense[2*s+:2] != 2'h0 && !lv[s] && pv[s]);
        end
    end

    // model registers: mux, two sync stages, previous level, outputs
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {s1, lv, pv, m_irq, m_rs, m_fs, m_pm, m_ev} <= '0;
        end else begin
            for (int c = 0; c < 8; c++) s1[c] <= pins[sel[6*c+:6]];
            lv <= s1;
            pv <= lv;
            m_rs <= (m_rs & ~rclr) | (lv & ~pv);
            m_fs <= (m_fs & ~fclr) | (~lv & pv);
            m_pm <= pm_n;
            m_ev <= ev_en & |pm_n & ~|m_pm;
            m_irq <= (mode == op_pattern) ? pm_n : ir_n;
        end
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %0t flag %b want %b", $time, g, e);
        end
    endtask

    // settled outputs are compared at the falling edge
    always @(negedge mclk_in) begin
        if (ck) begin
            chk8(irq, m_irq);
            chk8(rs, m_rs);
            chk8(fs, m_fs);
            chk8(pm, m_pm);
            chk1(ev, m_ev);
            chk1(evp, m_ev);
            chk1(twk, |m_pm & !deep);
            if (mode != op_pattern) begin
                chk1(pwk, |m_irq);
            end
        end
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, far above the roughly 630 cycles the run needs
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_of_test();
        end
    end

    // phases 0-3 edge senses, 4 level, 5-6 pattern
    initial begin
        repeat (3) @(posedge mclk_in);
        #1 rstn_in = 1;
        for (int ph = 0; ph < 7; ph++) begin
            ck = 0;
            sel = 48'({$random(seed), $random(seed)});
            sense = {8{2'(ph)}};
            lmode = (ph == 4) ? 8'hff : 8'h0;
            lhigh = 8'($random(seed));
            mode = (ph > 4) ? op_pattern : op_pin_irq;
            src = 24'($random(seed));
            cfg = 24'($random(seed));
            ends = 8'($random(seed) | $random(seed));
            ev_en = (ph == 5);
            repeat (90) begin
                @(posedge mclk_in);
                #1;
                want = want ^ ({$random(seed), $random(seed)} &
                               {$random(seed), $random(seed)});
                rclr = 8'($random(seed) & $random(seed));
                fclr = 8'($random(seed) & $random(seed));
                deep = 1'($random(seed));
                slow = 1'($random(seed));
                ck = 1;
            end
            $display("test %0d done", ph);
        end
        end_of_test();
    end
endmodule
